/* File: design/adc_readout_pkg.sv */
/*
 * Constants shared by the converter result readout port: code layout, timing, states.
 * Assumes a single 50 MHz system clock.
 */
package adc_readout_pkg;
    localparam int RESULT_W = 16;
    localparam int BYTE_W = 8;
    localparam int CLK_PERIOD_NS = 20;
    // Least convert pulse width.
    localparam int CONV_PULSE_NS = 40;
    localparam int CONV_PULSE_CYC = (CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Typical conversion time.
    localparam int CONV_TIME_NS = 19000;
    localparam int CONV_TIME_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
    // Delay from start of conversion to the first data clock.
    localparam int DCLK_DELAY_NS = 1400;
    localparam int DCLK_DELAY_CYC = DCLK_DELAY_NS / CLK_PERIOD_NS;
    // Internal data clock period, half high and half low.
    localparam int DCLK_PERIOD_NS = 1100;
    localparam int DCLK_HALF_CYC = DCLK_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam int SERIAL_BITS = 16;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] SIGN_FLIP = 16'h8000;
    localparam logic [15:0] TWOS_POS_FS = 16'h7FFF;
    localparam logic [15:0] TWOS_MID = 16'h0000;
    localparam logic [15:0] TWOS_NEG_FS = 16'h8000;
    localparam logic [15:0] SB_POS_FS = 16'hFFFF;
    localparam logic [15:0] SB_MID = 16'h8000;
    localparam logic [15:0] SB_NEG_FS = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONVERT = 2'b01
    } conv_state_t;
endpackage : adc_readout_pkg

/* File: design/adc_result_readout_port.sv */
/*
 * Result readout port of a 16-bit sampling converter: convert/read control,
 * output register, code format, byte mux, parallel bus enable, serial shifter
 * with internal or external data clock.
 * Assumes the analog core delivers a raw offset-binary sample on sample_i with
 * a one-cycle sample_valid_i pulse when a conversion ends; control pins are async.
 */
//
// Contract
// R1 - Format pin picks straight binary or twos complement.
// R2 - Twos complement codes 7FFF, 0000, 8000.
// R3 - Straight binary codes FFFF, 8000, 0000.
// R4 - Parallel reads leave output register intact.
// R5 - Each serial clock pulse shifts register once; external clock pulses shift only while select low and read high.
// R6 - Host ties clock source high, clock low.
// R7 - Bus driven only for select low, read high.
// R8 - Byte select low gives upper byte.
// R9 - Byte select high gives lower byte.
// R10 - Host may toggle byte select per conversion.
// R11 - Output content indeterminate before first conversion.
// R12 - Busy rises after register update; result on bus.
// R13 - Host may latch on busy rising edge.
// R14 - Internal clock: start converts, shifts previous result.
// R15 - External clock pin is input; conversion internal.
// R16 - External clock: ready result shifts on host clock.
// R17 - External clock during conversion shifts previous result.
// R18 - Both low at busy rise restarts conversion.
// R19 - Busy low ignores all convert commands.
// R20 - Both low 40 ns starts conversion; busy low.
// R21 - Internal mode: MSB first, exactly 16 pulses.
// R22 - One output register feeds byte mux, shifter.
`timescale 1ns/1ps
`default_nettype none
module adc_result_readout_port #(
    parameter int CONV_CYC = adc_readout_pkg::CONV_TIME_CYC
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic chip_select_b_i,
    input wire logic read_convert_i,
    input wire logic byte_select_i,
    input wire logic code_format_select_i,
    input wire logic serial_clock_source_select_i,
    input wire logic serial_bit_clock_i,
    input wire logic serial_tag_i,
    input wire logic [15:0] sample_i,
    input wire logic sample_valid_i,
    output logic conversion_start_o,
    output logic busy_b_o,
    output logic [7:0] parallel_result_bus_o,
    output logic parallel_result_bus_oe_o,
    output logic serial_result_out_o,
    output logic serial_bit_clock_o,
    output logic serial_bit_clock_oe_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic cs_b;
    logic rc;
    logic byte_sel;
    logic fmt_sb;
    logic ext_clk;
    logic dclk_in;
    logic tag;

    // Select and read/convert reset high, so the bus stays released and no command is seen as reset lifts.
    pin_sync #(.RESET_VAL(1'b1)) u_cs (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(chip_select_b_i),
        .sync_o(cs_b));
    pin_sync #(.RESET_VAL(1'b1)) u_rc (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(read_convert_i),
        .sync_o(rc));
    pin_sync #(.RESET_VAL(1'b0)) u_byte (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(byte_select_i),
        .sync_o(byte_sel));
    pin_sync #(.RESET_VAL(1'b0)) u_fmt (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(code_format_select_i),
        .sync_o(fmt_sb));
    pin_sync #(.RESET_VAL(1'b1)) u_ext (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .async_i(serial_clock_source_select_i), .sync_o(ext_clk));
    pin_sync #(.RESET_VAL(1'b0)) u_dclk (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(serial_bit_clock_i),
        .sync_o(dclk_in));
    pin_sync #(.RESET_VAL(1'b0)) u_tag (.clock_i(clock_i), .rst_b_i(rst_b_i), .async_i(serial_tag_i),
        .sync_o(tag));

    // ------------------------------------------------------------------
    // Convert control
    // ------------------------------------------------------------------
    adc_readout_pkg::conv_state_t state;
    adc_readout_pkg::conv_state_t next_state;
    logic [15:0] conv_cnt;
    logic [15:0] next_conv_cnt;
    logic [1:0] low_cnt;
    logic [1:0] next_low_cnt;
    logic both_low;
    logic start;
    logic conv_done;

    // Select and read/convert are OR'd: both low is a convert command.
    // The low count saturates, so a long command never wraps; held past busy rise it restarts a conversion.
    assign both_low = !cs_b && !rc;

    always_comb begin
        next_state = state;
        next_conv_cnt = conv_cnt;
        next_low_cnt = low_cnt;
        start = 1'b0;
        conv_done = 1'b0;
        case (state)
            adc_readout_pkg::ST_IDLE: begin
                if (both_low) begin
                    if (low_cnt < 2'(adc_readout_pkg::CONV_PULSE_CYC)) begin
                        next_low_cnt = low_cnt + 2'd1;
                    end
                end else begin
                    next_low_cnt = 2'd0;
                end
                // Level triggered, so a command still low when busy rises restarts at once.
                if (both_low && low_cnt + 2'd1 >= 2'(adc_readout_pkg::CONV_PULSE_CYC)) begin // R20 R18
                    start = 1'b1;
                    next_state = adc_readout_pkg::ST_CONVERT;
                    next_conv_cnt = 16'(CONV_CYC);
                end
            end
            adc_readout_pkg::ST_CONVERT: begin
                // Commands are not looked at here at all.
                next_low_cnt = 2'(adc_readout_pkg::CONV_PULSE_CYC); // R19
                if (conv_cnt != 16'h0000) begin
                    next_conv_cnt = conv_cnt - 16'h0001;
                end
                if (sample_valid_i || conv_cnt == 16'h0001) begin
                    conv_done = 1'b1;
                    next_state = adc_readout_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = adc_readout_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= adc_readout_pkg::ST_IDLE;
            conv_cnt <= 16'h0000;
            low_cnt <= 2'd0;
        end else begin
            state <= next_state;
            conv_cnt <= next_conv_cnt;
            low_cnt <= next_low_cnt;
        end
    end

    assign conversion_start_o = start;
    // Busy follows the state register, so it rises on the same clock edge that loads the output register.
    assign busy_b_o = (state == adc_readout_pkg::ST_IDLE); // R12

    // ------------------------------------------------------------------
    // Output register and serial shifter
    // ------------------------------------------------------------------
    logic [15:0] out_reg;
    logic [15:0] next_out_reg;
    logic [15:0] new_code;
    logic dclk_prev;
    logic dclk_fall;
    logic int_run;
    logic next_int_run;
    logic [4:0] bit_cnt;
    logic [4:0] next_bit_cnt;
    logic [7:0] half_cnt;
    logic [7:0] next_half_cnt;
    logic dclk_out;
    logic next_dclk_out;
    logic delay_done;
    logic shift;

    // The core delivers offset binary; twos complement flips the sign bit.
    assign new_code = fmt_sb ? sample_i : (sample_i ^ adc_readout_pkg::SIGN_FLIP); // R1 R2 R3

    // Outside internal mode the delay is held at zero, so a count loaded by an
    // external-clock conversion can never fire a burst after a later mode change.
    period_counter #(.WIDTH(8)) u_delay (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .load_i(start || ext_clk),
        .count_i(ext_clk ? 8'h00 : 8'(adc_readout_pkg::DCLK_DELAY_CYC)),
        .run_i(!ext_clk),
        .done_o(delay_done)
    );

    always_comb begin
        next_int_run = int_run;
        next_bit_cnt = bit_cnt;
        next_half_cnt = half_cnt;
        next_dclk_out = dclk_out;
        shift = 1'b0;
        if (delay_done && !ext_clk) begin // R14
            next_int_run = 1'b1;
            next_bit_cnt = 5'd0;
            next_half_cnt = 8'(adc_readout_pkg::DCLK_HALF_CYC);
            next_dclk_out = 1'b1;
        end else if (int_run) begin
            if (half_cnt > 8'd1) begin
                next_half_cnt = half_cnt - 8'd1;
            end else begin
                next_half_cnt = 8'(adc_readout_pkg::DCLK_HALF_CYC);
                next_dclk_out = !dclk_out;
                if (dclk_out) begin
                    // Falling edge of our own clock moves the next bit out.
                    shift = 1'b1; // R5
                    next_bit_cnt = bit_cnt + 5'd1;
                    if (bit_cnt == 5'(adc_readout_pkg::SERIAL_BITS - 1)) begin // R21
                        next_int_run = 1'b0;
                    end
                end
            end
        end
        // Leaving internal mode mid-burst parks our clock low instead of leaving a stray high phase.
        if (ext_clk) begin
            next_int_run = 1'b0;
            next_dclk_out = 1'b0;
        end
        // External clock shifts only while select low and read high.
        if (ext_clk && !cs_b && rc && dclk_fall) begin // R15 R16 R17
            shift = 1'b1; // R5
        end
        next_out_reg = out_reg;
        if (conv_done) begin
            next_out_reg = new_code; // R22
        end else if (shift) begin
            next_out_reg = {out_reg[14:0], tag};
        end
    end

    assign dclk_fall = dclk_prev && !dclk_in;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_reg <= adc_readout_pkg::RESULT_RESET; // R11
            dclk_prev <= 1'b0;
            int_run <= 1'b0;
            bit_cnt <= 5'd0;
            half_cnt <= 8'd0;
            dclk_out <= 1'b0;
        end else begin
            out_reg <= next_out_reg;
            dclk_prev <= dclk_in;
            int_run <= next_int_run;
            bit_cnt <= next_bit_cnt;
            half_cnt <= next_half_cnt;
            dclk_out <= next_dclk_out;
        end
    end

    // MSB leads; serial output is never tri-stated.
    assign serial_result_out_o = out_reg[15]; // R21
    assign serial_bit_clock_o = dclk_out;
    assign serial_bit_clock_oe_o = !ext_clk; // R15

    // ------------------------------------------------------------------
    // Parallel bus
    // ------------------------------------------------------------------
    // Reading the bus is a registered mux; nothing here writes the output register.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            parallel_result_bus_o <= 8'h00;
        end else begin
            parallel_result_bus_o <= byte_sel ? next_out_reg[7:0] : next_out_reg[15:8]; // R4 R8 R9
        end
    end
    assign parallel_result_bus_oe_o = !cs_b && rc; // R7

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    bus_enable_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R7
        parallel_result_bus_oe_o == ($past(rst_b_i, 2) && !$past(chip_select_b_i, 2)
            && $past(read_convert_i, 2))) else $error("bus enable wrong");
    upper_byte_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R8
        !byte_sel |=> parallel_result_bus_o == out_reg[15:8] || $past(byte_sel) != byte_sel)
        else $error("upper byte wrong");
    lower_byte_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R9
        byte_sel |=> parallel_result_bus_o == out_reg[7:0] || $past(byte_sel) != byte_sel)
        else $error("lower byte wrong");
    code_load_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R1
        conv_done |=> out_reg == ($past(fmt_sb) ? $past(sample_i) : ($past(sample_i) ^ 16'h8000)))
        else $error("code format wrong");
    busy_after_load_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R12
        conv_done |=> busy_b_o) else $error("busy did not rise");
    busy_ignores_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R19
        (!busy_b_o && both_low && !conv_done) |=> !busy_b_o) else $error("command taken while busy");
    start_busy_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R20
        start |=> !busy_b_o) else $error("busy not low after start");
    hold_parallel_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R4
        (!conv_done && !shift) |=> $stable(out_reg)) else $error("register changed");
    shift_step_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R5
        (shift && !conv_done) |=> out_reg[15:1] == $past(out_reg[14:0])) else $error("bad shift");
    pulse_count_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R21
        int_run |-> bit_cnt <= 5'd15) else $error("too many clock pulses");
    clock_idle_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R21
        !int_run |-> !serial_bit_clock_o) else $error("data clock active outside burst");
    restart_a: assert property (@(posedge clock_i) disable iff (!rst_b_i) // R18
        (conv_done && both_low) ##1 both_low |-> start) else $error("no restart at busy rise");
endmodule : adc_result_readout_port
`default_nettype wire

/* File: design/period_counter.sv */
/*
 * Down counter that pulses done_o when a loaded count has run out.
 * Assumes load_i and run_i come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module period_counter #(
    parameter int WIDTH = 10
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] count_i,
    input wire logic run_i,
    output logic done_o
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_done;

    always_comb begin
        next_count = count;
        next_done = 1'b0;
        if (load_i) begin
            next_count = count_i;
        end else if (run_i && count != '0) begin
            next_count = count - 1'b1;
            next_done = (count == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= '0;
            done_o <= 1'b0;
        end else begin
            count <= next_count;
            done_o <= next_done;
        end
    end
endmodule : period_counter
`default_nettype wire

/* File: design/pin_sync.sv */
/*
 * Two-flop synchroniser for one asynchronous level.
 * Assumes the level comes from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage1;
    logic stage2;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
        end
    end

    assign sync_o = stage2;
endmodule : pin_sync
`default_nettype wire

/* File: verif/serial_host_model.sv */
/*
 * Host side of the serial link: makes the external data clock in frames and
 * captures the result stream in either clocking mode.
 * Assumes the bench resolves the data clock pin from both drivers.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input wire logic ext_mode_i,
    input wire logic dclk_pin_i,
    input wire logic serial_result_out_i,
    output var logic host_clk_o
);
    int pulses = 0;
    logic [15:0] word = 16'h0000;

    // The clock stays low between frames, so no stray edge can shift the result away.
    initial host_clk_o = 1'b0;

    // Internal mode bits change on the falling edge; the rising edge keeps clear of the shift.
    always @(posedge dclk_pin_i) begin
        if (!ext_mode_i) begin
            pulses++;
            word = {word[14:0], serial_result_out_i};
        end
    end

    always @(negedge dclk_pin_i) begin
        if (ext_mode_i) begin
            word = {word[14:0], serial_result_out_i};
        end
    end

    task automatic clock_out(input int n);
        #7;
        repeat (n) begin
            host_clk_o = 1'b1;
            #80;
            host_clk_o = 1'b0;
            #80;
        end
    endtask : clock_out
endmodule : serial_host_model
`default_nettype wire

/* File: verif/tb.sv */
/*
 * Self-checking bench for the result readout port: output codes, byte reads,
 * ignored commands, serial reads on both clock sources, restart at busy rise.
 * Assumes the host model alone drives the data clock pin in external mode.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic cs_b = 1'b1;
    logic rc = 1'b1;
    logic byte_sel = 1'b0;
    logic fmt = 1'b0;
    logic ext_sel = 1'b1;
    logic tag = 1'b0;
    logic [15:0] sample = 16'h0000;
    logic sample_valid = 1'b0;
    logic start_pulse, busy_b, bus_oe, serial_result_out, dclk, dclk_oe, host_clk;
    logic [7:0] bus;
    wire logic dclk_pin = dclk_oe ? dclk : host_clk;
    int errors = 0;
    int tests_run = 0;
    int starts = 0;
    int n;
    logic [15:0] w;
    logic [15:0] raw [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
    logic [15:0] btc [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};

    initial forever #10 clock = ~clock;

    adc_result_readout_port #(.CONV_CYC(1000)) i_adc_result_readout_port (
        .clock_i(clock), .rst_b_i(rst_b), .chip_select_b_i(cs_b), .read_convert_i(rc),
        .byte_select_i(byte_sel), .code_format_select_i(fmt), .serial_clock_source_select_i(ext_sel),
        .serial_bit_clock_i(dclk_pin), .serial_tag_i(tag), .sample_i(sample),
        .sample_valid_i(sample_valid), .conversion_start_o(start_pulse), .busy_b_o(busy_b),
        .parallel_result_bus_o(bus), .parallel_result_bus_oe_o(bus_oe), .serial_result_out_o(serial_result_out),
        .serial_bit_clock_o(dclk), .serial_bit_clock_oe_o(dclk_oe));

    serial_host_model i_serial_host_model (.ext_mode_i(ext_sel), .dclk_pin_i(dclk_pin),
        .serial_result_out_i(serial_result_out), .host_clk_o(host_clk));

    always @(posedge clock) begin
        if (start_pulse === 1'b1) begin
            starts <= starts + 1;
        end
    end

    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic check1(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : check1

    task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check16

    // Samples at the falling clock edge so busy is read after its own update has landed.
    task automatic wait_busy(input logic lvl, input int limit);
        int k;
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (busy_b !== lvl && k < limit);
        check1("busy", lvl, busy_b);
        @(posedge clock);
    endtask : wait_busy

    task automatic start_conv(input logic [15:0] s);
        sample <= s;
        cs_b <= 1'b0;
        rc <= 1'b0;
        wait_busy(1'b0, 10);
        cs_b <= 1'b1;
        rc <= 1'b1;
        repeat (2) @(posedge clock);
        cs_b <= 1'b0;
        rc <= 1'b0;
        repeat (3) @(posedge clock);
        cs_b <= 1'b1;
        rc <= 1'b1;
    endtask : start_conv

    task automatic finish_conv(input logic pulse, input int limit);
        if (pulse) begin
            repeat (5) @(posedge clock);
            sample_valid <= 1'b1;
            @(posedge clock);
            sample_valid <= 1'b0;
        end
        wait_busy(1'b1, limit);
    endtask : finish_conv

    task automatic read_word(output logic [15:0] r);
        cs_b <= 1'b0;
        rc <= 1'b1;
        byte_sel <= 1'b0;
        repeat (5) @(negedge clock);
        check1("bus enable", 1'b1, bus_oe);
        r[15:8] = bus;
        @(posedge clock);
        byte_sel <= 1'b1;
        repeat (5) @(negedge clock);
        r[7:0] = bus;
        @(posedge clock);
        cs_b <= 1'b1;
        repeat (4) @(negedge clock);
        check1("bus enable", 1'b0, bus_oe);
        @(posedge clock);
    endtask : read_word

    task automatic end_sim;
        if (errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(negedge clock);
        check1("busy idle", 1'b1, busy_b);
        check1("bus enable", 1'b0, bus_oe);
        check1("clock drive", 1'b0, dclk_oe);
        @(posedge clock);
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < 4; k++) begin
                fmt <= f[0];
                start_conv(raw[k]);
                finish_conv(1'b1, 50);
                read_word(w);
                check16("code", (f == 1) ? raw[k] : btc[k], w);
            end
        end
        check16("start count", 16'd8, starts[15:0]);
        start_conv(16'hA5C3);
        finish_conv(1'b1, 50);
        read_word(w);
        check16("parallel first", 16'hA5C3, w);
        tag <= 1'b1;
        cs_b <= 1'b0;
        @(posedge clock);
        i_serial_host_model.word = 16'h0000;
        i_serial_host_model.clock_out(16);
        repeat (4) @(posedge clock);
        cs_b <= 1'b1;
        check16("serial word", 16'hA5C3, i_serial_host_model.word);
        read_word(w);
        check16("parallel after shift", 16'hFFFF, w);
        start_conv(16'h1234);
        finish_conv(1'b1, 50);
        ext_sel <= 1'b0;
        repeat (3) @(posedge clock);
        i_serial_host_model.pulses = 0;
        i_serial_host_model.word = 16'h0000;
        start_conv(16'h4321);
        check1("clock drive", 1'b1, dclk_oe);
        finish_conv(1'b0, 1100);
        check16("internal word", 16'h1234, i_serial_host_model.word);
        check16("pulse count", 16'd16, i_serial_host_model.pulses[15:0]);
        read_word(w);
        check16("timed result", 16'h4321, w);
        // Both pins held low across the busy rise must restart at once.
        ext_sel <= 1'b1;
        cs_b <= 1'b0;
        rc <= 1'b0;
        wait_busy(1'b0, 10);
        n = starts;
        finish_conv(1'b1, 50);
        wait_busy(1'b0, 10);
        check1("bus enable", 1'b0, bus_oe);
        check16("restart count", 16'(n + 1), starts[15:0]);
        cs_b <= 1'b1;
        rc <= 1'b1;
        finish_conv(1'b1, 50);
        end_sim();
    end

    // The sequence needs under 5000 cycles; four times that means a hang.
    initial begin
        #400000;
        errors++;
        end_sim();
    end
endmodule : tb
`default_nettype wire
